// ==== core/mbs_regs.svh ====
`ifndef MBS_REGS_SVH
`define MBS_REGS_SVH
`define MBS_CLK_HZ      20000000
`define MBS_BAUD        9600
`define MBS_GAP_MS      50
`define MBS_BIT_CYCLES  (`MBS_CLK_HZ / `MBS_BAUD)
`define MBS_GAP_CYCLES  (`MBS_GAP_MS * (`MBS_CLK_HZ / 1000))
`define MBS_SEC_CYCLES  (`MBS_CLK_HZ)
`define MBS_RUN_BIT     16'h0000
`define MBS_IN_LO       16'h0100
`define MBS_IN_HI       16'h017F
`define MBS_OUT_LO      16'h0200
`define MBS_OUT_HI      16'h02FF
`define MBS_MRK_LO      16'h2600
`define MBS_MRK_HI      16'h2DCF
`define MBS_AI_LO       16'h4600
`define MBS_AI_HI       16'h460F
`define MBS_AQ_LO       16'h4680
`define MBS_AQ_HI       16'h468F
`define MBS_AM_LO       16'h4700
`define MBS_AM_HI       16'h477F
`define MBS_D_LO        16'h4800
`define MBS_D_HI        16'h49FF
`define MBS_RTC_LO      16'h7FF9
`define MBS_RTC_HI      16'h7FFE
`define MBS_NODE_ADDR   16'h7FFF
`define MBS_PAR_BASE    16'h8000
`define MBS_RUN_BASE    16'hC000
`define MBS_FC_RD_BITS  8'h01
`define MBS_FC_RD_WORDS 8'h03
`define MBS_FC_WR_BIT   8'h05
`define MBS_FC_WR_WORDS 8'h10
`define MBS_FC_RD_CSW   8'h41
`define MBS_FC_WR_CSW   8'h42
`define MBS_EXC_FUNC    8'h01
`define MBS_EXC_ADDR    8'h02
`define MBS_EXC_VALUE   8'h03
`define MBS_EXC_FLAG    8'h80
`define MBS_COIL_ON     16'hFF00
`define MBS_COIL_OFF    16'h0000
`define MBS_NODE_MAX    16'h00FE
`define MBS_RTC_WORDS   16'h0004
`define MBS_MAX_RD_BITS 16'h07D0
`define MBS_MAX_RD_WRD  16'h007D
`define MBS_MAX_WR_WRD  16'h007B
`define MBS_CRC_INIT    16'hFFFF
`define MBS_CRC_POLY    16'hA001
`define MBS_MIN_FRAME   9'h004
`endif

// ==== core/mbs_pkg.sv ====
package mbs_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mbs_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} mbs_tx_t;
  typedef enum logic [2:0] {EX_IDLE, EX_DECODE, EX_RDBIT, EX_RDWORD, EX_CHECKWR, EX_WRWORD,
                            EX_WRBIT, EX_SEND} mbs_ex_t;
endpackage : mbs_pkg

// ==== core/mbs_slave.sv ====
// Notes on behaviour
// - output bits 200-2FF, read 01, write 05
// - marker bits 2600-2DCF, read 01, write 05
// - analog input words 4600-460F read-only
// - analog output words 4680-468F, read 03, write 10
// - scratch words 4700-477F, read 03, write 10
// - data words 4800-49FF, read 03, write 10
// - parameter at 8000 + block*32 + param*4
// - running value at C000 + block*32, read-only
// - clock-switch address block*256 + group*8
// - clock-switch access only by codes 41, 42
// - 9600 baud, 8 data, 1 stop, no parity
// - 50 ms silence separates frames
// - node address at 7FFF, values 0-254
// - run state is bit 0 at address 0
// - clock 7FF9-7FFE; read max 4, write 4
// - weekday Sunday 00 through Saturday 06
// - high-first order: low address holds upper half, except analog inputs (lower half first)
// - low-first order: low address holds lower half, except running values (upper half first)
// - parameter value spans two words
`timescale 1ns/1ps
`include "mbs_regs.svh"
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int           NBLK        = 320,
  parameter int           NCSW        = 8,
  parameter int           GAP_CYCLES  = `MBS_GAP_CYCLES,
  parameter int           SEC_CYCLES  = `MBS_SEC_CYCLES,
  parameter int           BIT_CYCLES  = `MBS_BIT_CYCLES,
  parameter logic [7:0]   NODE_RESET  = 8'h01
) (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               rxd,
  output logic                    txd,
  output logic                    txEnable,
  input  wire logic               running,
  input  wire logic               lowFirstWordOrder,
  input  wire logic [127:0]       inputBits,
  input  wire logic [255:0]       analogIn,
  input  wire logic [NBLK*32-1:0] runValues,
  output logic      [255:0]       outputBits,
  output logic      [255:0]       analogOut
);
  localparam int BIT_CYC = BIT_CYCLES;
  localparam int MRK_N   = int'(`MBS_MRK_HI - `MBS_MRK_LO) + 1;
  localparam int MEM_AM  = 0;
  localparam int MEM_D   = MEM_AM + int'(`MBS_AM_HI - `MBS_AM_LO) + 1;
  localparam int MEM_PAR = MEM_D + int'(`MBS_D_HI - `MBS_D_LO) + 1;
  localparam int MEM_CSW = MEM_PAR + NBLK * 16;
  localparam int MEM_N   = MEM_CSW + NCSW * 256;

  mbs_rx_t     rxState;
  mbs_tx_t     txState;
  mbs_ex_t     exState;
  logic [11:0] rxCnt;
  logic [2:0]  rxBits;
  logic [7:0]  rxShift;
  logic [8:0]  rxLen;
  logic [15:0] rxCrc;
  logic [31:0] silent;
  logic        frameStrobe;
  logic [7:0]  rxBuf [0:255];
  logic [7:0]  txBuf [0:255];
  logic [15:0] mem [0:MEM_N-1];
  logic [15:0] aqWords [0:15];
  logic [MRK_N-1:0] markerBits;
  logic [7:0]  node;
  logic [15:0] rtcYear;
  logic [7:0]  rtcMonth, rtcDay, rtcWeek, rtcHour, rtcMin, rtcSec;
  logic [7:0]  fc;
  logic [15:0] start, qty, i;
  logic [7:0]  acc;
  logic [7:0]  txLen;
  logic        txGo;
  logic [11:0] baudCnt;
  logic        baudTick;
  logic [31:0] secCnt;
  logic        secTick;
  logic [8:0]  txIdx;
  logic [3:0]  txBitCnt;
  logic [9:0]  txShift;
  logic [15:0] txCrc;
  logic [15:0] curAddr, swp, rdData, wrData, mrkOff;
  logic        rdOk, wrOk, memHit, aqHit, bitOk, bitVal, bitWrOk, isCsw;
  logic [31:0] memIdx;
  logic [8:0]  blk;
  logic [7:0]  wrPtr, rdPtr, next_acc;

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte

  function automatic logic [8:0] bcdInc(input logic [7:0] v, input logic [7:0] top);
    if (v == top) begin
      return 9'h100;
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v + 8'h01};
  endfunction : bcdInc

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : inRange

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxState <= RX_IDLE;
      rxCnt   <= 12'h000;
      rxBits  <= 3'h0;
      rxShift <= 8'h00;
    end else begin
      unique case (rxState)
        RX_IDLE: begin
          if (!rxd) begin
            rxState <= RX_START;
            rxCnt   <= 12'(BIT_CYC / 2);
          end
        end
        RX_START: begin
          if (rxCnt != 12'h000) begin
            rxCnt <= rxCnt - 12'h001;
          end else if (!rxd) begin
            rxState <= RX_DATA;
            rxCnt   <= 12'(BIT_CYC - 1);
            rxBits  <= 3'h0;
          end else begin
            rxState <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (rxCnt != 12'h000) begin
            rxCnt <= rxCnt - 12'h001;
          end else begin
            rxShift <= {rxd, rxShift[7:1]};
            rxCnt   <= 12'(BIT_CYC - 1);
            rxBits  <= rxBits + 3'h1;
            if (rxBits == 3'h7) begin
              rxState <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxCnt != 12'h000) begin
            rxCnt <= rxCnt - 12'h001;
          end else begin
            rxState <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // frame assembly; bytes arriving while a reply is pending are dropped (half duplex)
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rxLen       <= 9'h000;
      rxCrc       <= `MBS_CRC_INIT;
      silent      <= 32'h0;
      frameStrobe <= 1'b0;
    end else begin
      frameStrobe <= 1'b0;
      if (rxState != RX_IDLE || !rxd) begin
        silent <= 32'h0;
      end else if (silent != 32'(GAP_CYCLES)) begin
        silent <= silent + 32'h1;
      end
      if (rxState == RX_STOP && rxCnt == 12'h000 && rxd && exState == EX_IDLE
          && !rxLen[8]) begin
        rxBuf[rxLen[7:0]] <= rxShift;
        rxLen             <= rxLen + 9'h001;
        rxCrc             <= crcByte(rxCrc, rxShift);
      end
      if (silent == 32'(GAP_CYCLES - 1) && rxLen != 9'h000) begin
        frameStrobe <= rxLen >= `MBS_MIN_FRAME && !rxLen[8] && rxCrc == 16'h0000
                       && rxBuf[0] == node;
        rxLen       <= 9'h000;
        rxCrc       <= `MBS_CRC_INIT;
      end
    end
  end

  always_comb begin
    isCsw   = fc == `MBS_FC_RD_CSW || fc == `MBS_FC_WR_CSW;
    curAddr = start + i;
    swp     = {curAddr[15:1], curAddr[0] ^ ~lowFirstWordOrder};
    blk     = curAddr[13:5];
    mrkOff  = curAddr - `MBS_MRK_LO;
    wrPtr   = {i[6:0], 1'b0} + 8'h07;
    rdPtr   = {i[6:0], 1'b0} + 8'h03;
    wrData  = {rxBuf[wrPtr], rxBuf[wrPtr + 8'h01]};
    rdOk    = 1'b0;
    wrOk    = 1'b0;
    memHit  = 1'b0;
    aqHit   = 1'b0;
    memIdx  = 32'h0;
    rdData  = 16'h0000;
    if (isCsw) begin
      if (32'(curAddr) < NCSW * 256) begin
        memHit = 1'b1;
        memIdx = MEM_CSW + 32'(curAddr);
      end
    end else if (inRange(curAddr, `MBS_AI_LO, `MBS_AI_HI)) begin
      rdOk   = 1'b1;
      rdData = analogIn[curAddr[3:0]*16 +: 16];
    end else if (inRange(curAddr, `MBS_AQ_LO, `MBS_AQ_HI)) begin
      aqHit  = 1'b1;
      rdData = aqWords[swp[3:0]];
    end else if (inRange(curAddr, `MBS_AM_LO, `MBS_AM_HI)) begin
      memHit = 1'b1;
      memIdx = MEM_AM + 32'(swp[6:0]);
    end else if (inRange(curAddr, `MBS_D_LO, `MBS_D_HI)) begin
      memHit = 1'b1;
      memIdx = MEM_D + 32'(swp[8:0]);
    end else if (inRange(curAddr, `MBS_RTC_LO, `MBS_RTC_HI)) begin
      rdOk = 1'b1;
      wrOk = 1'b1;
      unique case (curAddr[2:0])
        3'h1:    rdData = rtcYear;
        3'h2:    rdData = {rtcMonth, rtcDay};
        3'h3:    rdData = {rtcWeek, rtcHour};
        3'h4:    rdData = {rtcMin, rtcSec};
        default: rdData = 16'h0000;
      endcase
    end else if (curAddr == `MBS_NODE_ADDR) begin
      rdOk   = 1'b1;
      wrOk   = 1'b1;
      rdData = {8'h00, node};
    end else if (curAddr >= `MBS_PAR_BASE && curAddr < `MBS_RUN_BASE) begin
      // block*32 + param*4, two words each
      if (32'(blk) < NBLK && !curAddr[1]) begin
        memHit = 1'b1;
        memIdx = MEM_PAR + 32'({swp[13:2], swp[0]});
      end
    end else if (curAddr >= `MBS_RUN_BASE) begin
      // parameter zero only, upper half first
      if (32'(blk) < NBLK && curAddr[4:1] == 4'h0) begin
        rdOk   = 1'b1;
        rdData = runValues[32'(blk)*32 + (curAddr[0] ? 0 : 16) +: 16];
      end
    end
    if (memHit) begin
      rdOk   = 1'b1;
      wrOk   = 1'b1;
      rdData = mem[memIdx];
    end
    if (aqHit) begin
      rdOk = 1'b1;
      wrOk = 1'b1;
    end
    bitOk   = 1'b0;
    bitWrOk = 1'b0;
    bitVal  = 1'b0;
    if (curAddr == `MBS_RUN_BIT) begin
      bitOk  = 1'b1;
      bitVal = running;
    end else if (inRange(curAddr, `MBS_IN_LO, `MBS_IN_HI)) begin
      bitOk  = 1'b1;
      bitVal = inputBits[curAddr[6:0]];
    end else if (inRange(curAddr, `MBS_OUT_LO, `MBS_OUT_HI)) begin
      bitOk   = 1'b1;
      bitWrOk = 1'b1;
      bitVal  = outputBits[curAddr[7:0]];
    end else if (inRange(curAddr, `MBS_MRK_LO, `MBS_MRK_HI)) begin
      bitOk   = 1'b1;
      bitWrOk = 1'b1;
      bitVal  = markerBits[mrkOff[10:0]];
    end
    next_acc = acc | ({7'h00, bitVal} << i[2:0]);
  end

  // command interpreter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      exState <= EX_IDLE;
      fc      <= 8'h00;
      start   <= 16'h0000;
      qty     <= 16'h0000;
      i       <= 16'h0000;
      acc     <= 8'h00;
      txLen   <= 8'h00;
      txGo    <= 1'b0;
    end else begin
      txGo <= 1'b0;
      unique case (exState)
        EX_IDLE: begin
          if (frameStrobe) begin
            fc      <= rxBuf[1];
            start   <= {rxBuf[2], rxBuf[3]};
            qty     <= {rxBuf[4], rxBuf[5]};
            i       <= 16'h0000;
            acc     <= 8'h00;
            exState <= EX_DECODE;
          end
        end
        EX_DECODE: begin
          txBuf[0] <= node;
          txBuf[1] <= fc;
          txBuf[2] <= rxBuf[2];
          txBuf[3] <= rxBuf[3];
          txBuf[4] <= rxBuf[4];
          txBuf[5] <= rxBuf[5];
          txLen    <= 8'h06;
          exState  <= EX_SEND;
          txGo     <= 1'b1;
          if (fc == `MBS_FC_RD_BITS) begin
            if (qty == 16'h0000 || qty > `MBS_MAX_RD_BITS) begin
              txBuf[1] <= fc | `MBS_EXC_FLAG;
              txBuf[2] <= `MBS_EXC_VALUE;
              txLen    <= 8'h03;
            end else begin
              txBuf[2] <= 8'((qty + 16'h0007) >> 3);
              exState  <= EX_RDBIT;
              txGo     <= 1'b0;
            end
          end else if (fc == `MBS_FC_RD_WORDS || fc == `MBS_FC_RD_CSW) begin
            // at most four clock words per read
            if (qty == 16'h0000 || qty > `MBS_MAX_RD_WRD || (fc == `MBS_FC_RD_WORDS
                && inRange(start, `MBS_RTC_LO, `MBS_RTC_HI) && qty > `MBS_RTC_WORDS)) begin
              txBuf[1] <= fc | `MBS_EXC_FLAG;
              txBuf[2] <= `MBS_EXC_VALUE;
              txLen    <= 8'h03;
            end else begin
              txBuf[2] <= {qty[6:0], 1'b0};
              exState  <= EX_RDWORD;
              txGo     <= 1'b0;
            end
          end else if (fc == `MBS_FC_WR_BIT) begin
            if (qty != `MBS_COIL_ON && qty != `MBS_COIL_OFF) begin
              txBuf[1] <= fc | `MBS_EXC_FLAG;
              txBuf[2] <= `MBS_EXC_VALUE;
              txLen    <= 8'h03;
            end else if (!bitWrOk) begin
              txBuf[1] <= fc | `MBS_EXC_FLAG;
              txBuf[2] <= `MBS_EXC_ADDR;
              txLen    <= 8'h03;
            end else begin
              exState <= EX_WRBIT;
              txGo    <= 1'b0;
            end
          end else if (fc == `MBS_FC_WR_WORDS || fc == `MBS_FC_WR_CSW) begin
            // clock writes carry exactly four words from the first
            if (qty == 16'h0000 || qty > `MBS_MAX_WR_WRD || rxBuf[6] != {qty[6:0], 1'b0}
                || (fc == `MBS_FC_WR_WORDS && inRange(start, `MBS_RTC_LO, `MBS_RTC_HI)
                && (start != `MBS_RTC_LO || qty != `MBS_RTC_WORDS))) begin
              txBuf[1] <= fc | `MBS_EXC_FLAG;
              txBuf[2] <= `MBS_EXC_VALUE;
              txLen    <= 8'h03;
            end else begin
              exState <= EX_CHECKWR;
              txGo    <= 1'b0;
            end
          end else begin
            // anything else is an unknown function
            txBuf[1] <= fc | `MBS_EXC_FLAG;
            txBuf[2] <= `MBS_EXC_FUNC;
            txLen    <= 8'h03;
          end
        end
        EX_RDBIT: begin
          i <= i + 16'h0001;
          if (!bitOk) begin
            txBuf[1] <= fc | `MBS_EXC_FLAG;
            txBuf[2] <= `MBS_EXC_ADDR;
            txLen    <= 8'h03;
            exState  <= EX_SEND;
            txGo     <= 1'b1;
          end else begin
            acc <= next_acc;
            if (i[2:0] == 3'h7 || i == qty - 16'h0001) begin
              txBuf[8'h03 + i[10:3]] <= next_acc;
              acc                    <= 8'h00;
            end
            if (i == qty - 16'h0001) begin
              txLen   <= 8'h03 + txBuf[2];
              exState <= EX_SEND;
              txGo    <= 1'b1;
            end
          end
        end
        EX_RDWORD: begin
          i <= i + 16'h0001;
          if (!rdOk) begin
            txBuf[1] <= fc | `MBS_EXC_FLAG;
            txBuf[2] <= `MBS_EXC_ADDR;
            txLen    <= 8'h03;
            exState  <= EX_SEND;
            txGo     <= 1'b1;
          end else begin
            txBuf[rdPtr]         <= rdData[15:8];
            txBuf[rdPtr + 8'h01] <= rdData[7:0];
            if (i == qty - 16'h0001) begin
              txLen   <= 8'h03 + txBuf[2];
              exState <= EX_SEND;
              txGo    <= 1'b1;
            end
          end
        end
        // whole request checked first so a bad word leaves nothing half written
        EX_CHECKWR: begin
          i <= i + 16'h0001;
          if (!wrOk) begin
            txBuf[1] <= fc | `MBS_EXC_FLAG;
            txBuf[2] <= `MBS_EXC_ADDR;
            txLen    <= 8'h03;
            exState  <= EX_SEND;
            txGo     <= 1'b1;
          end else if (!isCsw && curAddr == `MBS_NODE_ADDR && wrData > `MBS_NODE_MAX) begin
            txBuf[1] <= fc | `MBS_EXC_FLAG;
            txBuf[2] <= `MBS_EXC_VALUE;
            txLen    <= 8'h03;
            exState  <= EX_SEND;
            txGo     <= 1'b1;
          end else if (i == qty - 16'h0001) begin
            i       <= 16'h0000;
            exState <= EX_WRWORD;
          end
        end
        EX_WRWORD: begin
          i <= i + 16'h0001;
          if (i == qty - 16'h0001) begin
            exState <= EX_SEND;
            txGo    <= 1'b1;
          end
        end
        EX_WRBIT: begin
          exState <= EX_SEND;
          txGo    <= 1'b1;
        end
        EX_SEND: begin
          if (!txGo && txState == TX_IDLE) begin
            exState <= EX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (exState == EX_WRWORD && memHit) begin
      mem[memIdx] <= wrData;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < 16; k++) begin
        aqWords[k] <= 16'h0000;
      end
    end else if (exState == EX_WRWORD && aqHit) begin
      aqWords[swp[3:0]] <= wrData;
    end
  end

  generate
    for (genvar g = 0; g < 16; g++) begin : gAq
      assign analogOut[g*16 +: 16] = aqWords[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      outputBits <= '0;
      markerBits <= '0;
    end else if (exState == EX_WRBIT) begin
      if (inRange(curAddr, `MBS_OUT_LO, `MBS_OUT_HI)) begin
        outputBits[curAddr[7:0]] <= qty == `MBS_COIL_ON;
      end else begin
        markerBits[mrkOff[10:0]] <= qty == `MBS_COIL_ON;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      node <= NODE_RESET;
    end else if (exState == EX_WRWORD && !isCsw && curAddr == `MBS_NODE_ADDR) begin
      node <= wrData[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      secCnt  <= 32'h0;
      secTick <= 1'b0;
    end else begin
      secTick <= secCnt == 32'(SEC_CYCLES - 1);
      secCnt  <= (secCnt == 32'(SEC_CYCLES - 1)) ? 32'h0 : secCnt + 32'h1;
    end
  end

  // BCD fields; the date itself does not roll over
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rtcYear  <= 16'h0000;
      rtcMonth <= 8'h01;
      rtcDay   <= 8'h01;
      rtcWeek  <= 8'h00;
      rtcHour  <= 8'h00;
      rtcMin   <= 8'h00;
      rtcSec   <= 8'h00;
    end else if (exState == EX_WRWORD && !isCsw && curAddr == `MBS_RTC_LO) begin
      rtcYear  <= {rxBuf[7], rxBuf[8]};
      rtcMonth <= rxBuf[9];
      rtcDay   <= rxBuf[10];
      rtcWeek  <= rxBuf[11];
      rtcHour  <= rxBuf[12];
      rtcMin   <= rxBuf[13];
      rtcSec   <= rxBuf[14];
    end else if (secTick) begin
      rtcSec <= 8'(bcdInc(rtcSec, 8'h59));
      if (rtcSec == 8'h59) begin
        rtcMin <= 8'(bcdInc(rtcMin, 8'h59));
        if (rtcMin == 8'h59) begin
          rtcHour <= 8'(bcdInc(rtcHour, 8'h23));
          if (rtcHour == 8'h23) begin
            // Saturday 06 wraps to Sunday 00
            rtcWeek <= 8'(bcdInc(rtcWeek, 8'h06));
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      baudCnt  <= 12'h000;
      baudTick <= 1'b0;
    end else begin
      baudTick <= baudCnt == 12'(BIT_CYC - 1);
      baudCnt  <= (baudCnt == 12'(BIT_CYC - 1)) ? 12'h000 : baudCnt + 12'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txState  <= TX_IDLE;
      txd      <= 1'b1;
      txIdx    <= 9'h000;
      txBitCnt <= 4'h0;
      txShift  <= 10'h3FF;
      txCrc    <= `MBS_CRC_INIT;
    end else begin
      unique case (txState)
        TX_IDLE: begin
          if (txGo) begin
            txState <= TX_LOAD;
            txIdx   <= 9'h000;
            txCrc   <= `MBS_CRC_INIT;
          end
        end
        TX_LOAD: begin
          txBitCnt <= 4'h0;
          txState  <= TX_SHIFT;
          if (txIdx == {1'b0, txLen} + 9'h003) begin
            txState <= TX_IDLE;
          end else if (txIdx == {1'b0, txLen} + 9'h002) begin
            // keep the driver enabled until the last stop bit has stood a full bit
            txShift  <= 10'h3FF;
            txBitCnt <= 4'h9;
          end else if (txIdx < {1'b0, txLen}) begin
            txShift <= {1'b1, txBuf[txIdx[7:0]], 1'b0};
            txCrc   <= crcByte(txCrc, txBuf[txIdx[7:0]]);
          end else if (txIdx == {1'b0, txLen}) begin
            txShift <= {1'b1, txCrc[7:0], 1'b0};
          end else begin
            txShift <= {1'b1, txCrc[15:8], 1'b0};
          end
        end
        TX_SHIFT: begin
          if (baudTick) begin
            txd      <= txShift[0];
            txShift  <= {1'b1, txShift[9:1]};
            txBitCnt <= txBitCnt + 4'h1;
            if (txBitCnt == 4'h9) begin
              txIdx   <= txIdx + 9'h001;
              txState <= TX_LOAD;
            end
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  assign txEnable = txState != TX_IDLE;
endmodule : mbs_slave

// ==== testbench/mbs_slave_props.sv ====
`timescale 1ns/1ps
module mbs_slave_props #(
  parameter int GAP_CYCLES = 1000000,
  parameter int BIT_CYCLES = 2083
) (
  input wire logic         clock,
  input wire logic         rst_b,
  input wire logic         rxd,
  input wire logic         txd,
  input wire logic         txEnable,
  input wire logic [255:0] outputBits,
  input wire logic [255:0] analogOut
);
  int idle;
  int hold;
  always_ff @(posedge clock) idle <= rxd ? idle + 1 : 0;
  always_ff @(posedge clock) hold <= $changed(txd) ? 0 : hold + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b [*2] |->
    txd && !txEnable && outputBits == '0 && analogOut == '0) else $error("reset state");
  a_idle_high: assert property (!txEnable |-> txd) else $error("txd low idle");
  a_bit_width: assert property ($changed(txd) |-> txEnable && hold >= BIT_CYCLES - 1)
    else $error("short bit");
  a_stop_level: assert property ($fell(txEnable) |-> txd && $past(txd))
    else $error("no stop bit");
  a_stop_hold: assert property ($fell(txEnable) |-> hold >= BIT_CYCLES - 1)
    else $error("short stop");
  a_reply_gap: assert property ($rose(txEnable) |-> idle >= GAP_CYCLES - 4)
    else $error("reply early");
  a_bit_write_gap: assert property ($changed(outputBits) |-> idle >= GAP_CYCLES - 4)
    else $error("bit write early");
  a_word_write_gap: assert property ($changed(analogOut) |-> idle >= GAP_CYCLES - 4)
    else $error("word write early");
  cover property ($rose(txEnable));
  cover property ($changed(outputBits));
  cover property ($changed(analogOut));
endmodule : mbs_slave_props
bind mbs_slave mbs_slave_props #(.GAP_CYCLES(GAP_CYCLES), .BIT_CYCLES(BIT_CYCLES)) props_u (
  .clock(clock),
  .rst_b(rst_b), .rxd(rxd), .txd(txd), .txEnable(txEnable), .outputBits(outputBits),
  .analogOut(analogOut));

// ==== testbench/mbs_master_model.sv ====
`timescale 1ns/1ps
module mbs_master_model #(
  parameter int GAP = 3000,
  parameter int BIT = 2083
) (
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd
);
  logic [15:0] crc;
  initial rxd = 1'b1;
  function automatic logic [15:0] crc16(logic [15:0] c, logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction : crc16
  task automatic put(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      #1 rxd = f[i];
      repeat (BIT) @(posedge clock);
    end
    crc = crc16(crc, d);
  endtask : put
  // silence first, crc low byte first
  task automatic frame(input logic [87:0] v, input int n, input logic bad);
    logic [15:0] c;
    // get returns mid stop bit, so one extra bit keeps the full gap on the line
    repeat (GAP + BIT) @(posedge clock);
    crc = 16'hFFFF;
    for (int i = 0; i < n; i++)
      put(v[8 * (n - 1 - i) +: 8]);
    c = crc ^ {15'h0, bad};
    put(c[7:0]);
    put(c[15:8]);
  endtask : frame
  task automatic get(output logic [7:0] d);
    for (int t = 0; t < 60000 && txd !== 1'b0; t++)
      @(posedge clock);
    repeat (BIT / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock);
      d[i] = txd;
    end
    repeat (BIT) @(posedge clock);
    crc = crc16(crc, d);
  endtask : get
endmodule : mbs_master_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [87:0] q; int nq; logic [87:0] r; int nr;} mbs_row_t;
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         rxd;
  logic         txd;
  logic         txEnable;
  logic [255:0] outputBits;
  logic [255:0] analogOut;
  logic         running = 1'b1;
  logic         lowFirstWordOrder = 1'b0;
  logic [127:0] inputBits = '0;
  logic [255:0] analogIn = 256'hA5C3;
  logic [10239:0] runValues = '0;
  logic [7:0]   b;
  int           fails = 0;
  int           n_compared = 0;
  int           cyc = 0;
  mbs_row_t rows[8] = '{
    '{88'h010346000001, 6, 88'h010302A5C3, 5},
    '{88'h0110800000020400030D40, 11, 88'h011080000002, 6},
    '{88'h010380000002, 6, 88'h01030400030D40, 7},
    '{88'h010100000001, 6, 88'h01010101, 4},
    '{88'h010700000001, 6, 88'h018701, 3},
    '{88'h011046000001020000, 9, 88'h019002, 3},
    '{88'h01050203FF00, 6, 88'h01050203FF00, 6},
    '{88'h011046800001021234, 9, 88'h011046800001, 6}};
  always #25 clock = ~clock;
  mbs_slave #(.GAP_CYCLES(100), .BIT_CYCLES(20)) dut_u (.clock(clock),
    .rst_b(rst_b), .rxd(rxd), .txd(txd), .txEnable(txEnable), .running(running),
    .lowFirstWordOrder(lowFirstWordOrder), .inputBits(inputBits), .analogIn(analogIn),
    .runValues(runValues), .outputBits(outputBits), .analogOut(analogOut));
  mbs_master_model #(.GAP(100), .BIT(20)) master_u (.clock(clock), .txd(txd), .rxd(rxd));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      master_u.frame(rows[i].q, rows[i].nq, 1'b0);
      master_u.crc = 16'hFFFF;
      for (int k = 0; k < rows[i].nr + 2; k++) begin
        master_u.get(b);
        if (k < rows[i].nr)
          check("reply byte", rows[i].r[8 * (rows[i].nr - 1 - k) +: 8], b);
      end
      check("reply crc", 16'h0, master_u.crc);
      $display("row %0d done", i);
    end
    #1 running = 1'b0;
    lowFirstWordOrder = 1'b1;
    master_u.frame(88'h011046800001025678, 9, 1'b0);
    repeat (2500) @(posedge clock);
    check("word 0", 16'h5678, analogOut[15:0]);
    master_u.frame(88'h010100000001, 6, 1'b0);
    for (int k = 0; k < 6; k++) begin
      master_u.get(b);
      if (k == 3)
        check("run bit", 16'h0, {8'h0, b});
    end
    master_u.frame(88'h01050204FF00, 6, 1'b1);
    // inside the window where a reply to an accepted frame would be on the line
    repeat (200) @(posedge clock);
    check("silent", 16'h0, {15'h0, txEnable});
    check("bit 4", 16'h0, {15'h0, outputBits[4]});
    check("bit 3", 16'h1, {15'h0, outputBits[3]});
    check("word 1", 16'h1234, analogOut[31:16]);
    #1 rst_b = 1'b0;
    #1 check("reset bit 3", 16'h0, {15'h0, outputBits[3]});
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    $display("hand tests done");
    wrap_up();
  end
endmodule : testbench
